// ==== hdl/hp_pkg.sv ====
// hp_pkg: constants, field layouts and pin carriers for the parallel host controller.
// assumes a 10 MHz core clock; the device pins are joined by the bench.
package hp_pkg;
  localparam int CLK_NS = 100;
  localparam int SYNC_STAGES = 2;
  // minimum strobe width on either handshake line, in ns
  localparam int STROBE_NS = 250;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  // data settle before the input strobe, covering the device's rising-edge filter delay
  localparam int SETUP_NS = 150;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  // after the trailing edge the device drops its ready lines within this time
  localparam int RELEASE_NS = 400;
  localparam int RELEASE_CYC = (RELEASE_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
  // one cycle for the select pin register, then the synchroniser, before data is trusted
  localparam int SETTLE_CYC = SYNC_STAGES + 2;
  localparam int CNT_W = 3;

  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_TXDATA = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_RXDATA = 4'hc;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [1:0] MODE_IRQ = 2'h0;
  localparam logic [1:0] MODE_POLL = 2'h1;
  localparam logic [1:0] MODE_LEVEL = 2'h2;

  localparam int CHAR_W = 7;
  localparam int CFG_W = 7;
  localparam int STAT_BUSY = 0;
  localparam int STAT_RXVALID = 1;
  localparam int STAT_ACCEPT = 2;
  localparam int STAT_SRQ = 3;

  typedef struct packed {
    logic [1:0] mode;
    logic ordy_high;
    logic xsel_high;
    logic rfo_pos;
    logic strobe_rise;
    logic data_inv;
  } hp_cfg_t;

  localparam hp_cfg_t CFG_RST = 7'h1f;

  // lines the host receives from the device
  typedef struct packed {
    logic rx_accept_flag;
    logic [CHAR_W-1:0] out_data;
    logic out_ready_ts;
    logic out_ready_ttl;
    logic service_req_n;
  } hp_dev_in_t;

  // lines the host drives toward the device
  typedef struct packed {
    logic [CHAR_W-1:0] in_data;
    logic in_strobe;
    logic xmit_sel;
    logic ready_for_output;
  } hp_dev_out_t;

  localparam int DEV_IN_W = $bits(hp_dev_in_t);
endpackage

// ==== hdl/hp_sync.sv ====
// hp_sync: two-flop synchroniser, one per bit.
// assumes inputs are asynchronous levels; only the second stage is visible.
`timescale 1ns/10ps
module hp_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_r;
      logic sync_r;
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= d[i];
          sync_r <= meta_r;
        end
      end
      assign q[i] = sync_r;
    end
  endgenerate
endmodule

// ==== hdl/hp_host.sv ====
// hp_host: host-side controller for the parallel terminal port, reached over AXI4-Lite.
// assumes the device pins are resolved by the bench; all device inputs are asynchronous.
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module hp_host
  import hp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire hp_dev_in_t dev_i,
  output hp_dev_out_t dev_o
);
  typedef enum logic [2:0] {TX_IDLE, TX_WAIT_RDY, TX_SETUP, TX_STROBE, TX_WAIT_BUSY,
                            TX_WAIT_FREE} hp_tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_SEL, RX_ACK, RX_REL} hp_rx_state_t;

  // service request idles high: flip it so the synchroniser's reset level reads as idle
  localparam hp_dev_in_t SYNC_FLIP = '{service_req_n: 1'b1, default: '0};
  hp_dev_in_t din, sync_q;
  hp_sync #(.W(DEV_IN_W)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .d(dev_i ^ SYNC_FLIP),
    .q(sync_q)
  );
  assign din = sync_q ^ SYNC_FLIP;

  // bus group
  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [3:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic wstrb0_r, wstrb0_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  hp_cfg_t cfg_r, cfg_nxt;
  logic wr_tx, rd_rx;

  // transfer groups
  hp_tx_state_t tx_st_r, tx_st_nxt;
  hp_rx_state_t rx_st_r, rx_st_nxt;
  logic [CHAR_W-1:0] tx_char_r, tx_char_nxt, rx_char_r, rx_char_nxt;
  logic [CNT_W-1:0] tx_cnt_r, tx_cnt_nxt, rx_cnt_r, rx_cnt_nxt;
  logic rx_valid_r, rx_valid_nxt;
  hp_dev_out_t pins_r, pins_nxt;
  logic strobe_act, sel_act, rfo_act;
  logic ordy_seen;

  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt = w_hold_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb0_nxt = wstrb0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    cfg_nxt = cfg_r;
    wr_tx = 1'b0;
    rd_rx = 1'b0;
    if (s_axi_awvalid && awready_r) begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_hold_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb0_nxt = s_axi_wstrb[0];
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (aw_hold_r && w_hold_r && !bvalid_r) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      if (awaddr_r == ADDR_CTRL) begin
        if (wstrb0_r) begin
          cfg_nxt = wdata_r[CFG_W-1:0];
        end
      end else if (awaddr_r == ADDR_TXDATA) begin
        wr_tx = wstrb0_r;
      end else if (awaddr_r != ADDR_STATUS && awaddr_r != ADDR_RXDATA) begin
        bresp_nxt = RESP_SLVERR;
      end
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      rdata_nxt = 32'h0;
      unique case (s_axi_araddr)
        ADDR_CTRL: rdata_nxt[CFG_W-1:0] = cfg_r;
        ADDR_TXDATA: rdata_nxt[CHAR_W-1:0] = tx_char_r;
        ADDR_STATUS: begin
          rdata_nxt[STAT_BUSY] = (tx_st_r != TX_IDLE);
          rdata_nxt[STAT_RXVALID] = rx_valid_r;
          rdata_nxt[STAT_ACCEPT] = din.rx_accept_flag;
          rdata_nxt[STAT_SRQ] = !din.service_req_n;
        end
        ADDR_RXDATA: begin
          rdata_nxt[CHAR_W-1:0] = rx_char_r;
          rd_rx = 1'b1;
        end
        default: rresp_nxt = RESP_SLVERR;
      endcase
    end
    awready_nxt = !aw_hold_nxt && !bvalid_nxt;
    wready_nxt = !w_hold_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0;
      wstrb0_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0;
      cfg_r <= CFG_RST;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb0_r <= wstrb0_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  // a write to the transmit register while a character is in flight is dropped
  always_comb begin
    tx_st_nxt = tx_st_r;
    tx_char_nxt = tx_char_r;
    tx_cnt_nxt = tx_cnt_r;
    strobe_act = 1'b0;
    unique case (tx_st_r)
      TX_IDLE: begin
        if (wr_tx) begin
          tx_char_nxt = wdata_r[CHAR_W-1:0];
          tx_st_nxt = TX_WAIT_RDY;
        end
      end
      TX_WAIT_RDY: begin
        if (din.rx_accept_flag) begin
          tx_cnt_nxt = CNT_W'(SETUP_CYC);
          tx_st_nxt = TX_SETUP;
        end
      end
      TX_SETUP: begin
        tx_cnt_nxt = tx_cnt_r - 1'b1;
        if (tx_cnt_r == CNT_W'(1)) begin
          tx_cnt_nxt = CNT_W'(STROBE_CYC);
          tx_st_nxt = TX_STROBE;
        end
      end
      TX_STROBE: begin
        strobe_act = 1'b1;
        tx_cnt_nxt = tx_cnt_r - 1'b1;
        if (tx_cnt_r == CNT_W'(1)) begin
          tx_st_nxt = TX_WAIT_BUSY;
        end
      end
      TX_WAIT_BUSY: begin
        // data stays put until the device shows it has taken the character
        if (!din.rx_accept_flag) begin
          tx_st_nxt = TX_WAIT_FREE;
        end
      end
      TX_WAIT_FREE: begin
        if (din.rx_accept_flag) begin
          tx_st_nxt = TX_IDLE;
        end
      end
      default: tx_st_nxt = TX_IDLE;
    endcase
  end

  // receive side; a new character is not acknowledged until software has read the last
  always_comb begin
    rx_st_nxt = rx_st_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_char_nxt = rx_char_r;
    rx_valid_nxt = rx_valid_r;
    sel_act = (cfg_r.mode == MODE_POLL);
    rfo_act = (cfg_r.mode == MODE_LEVEL);
    ordy_seen = 1'b0;
    if (rd_rx) begin
      rx_valid_nxt = 1'b0;
    end
    unique case (cfg_r.mode)
      MODE_POLL: ordy_seen = (din.out_ready_ts == cfg_r.ordy_high);
      MODE_LEVEL: ordy_seen = din.out_ready_ttl;
      default: ordy_seen = !din.service_req_n;
    endcase
    unique case (rx_st_r)
      RX_IDLE: begin
        // the select pin must stand through the synchroniser before its ready line is believed
        if (pins_r.xmit_sel != (sel_act ~^ cfg_r.xsel_high)) begin
          rx_cnt_nxt = CNT_W'(SETTLE_CYC);
        end else if (rx_cnt_r != '0) begin
          rx_cnt_nxt = rx_cnt_r - 1'b1;
        end else if (ordy_seen && !rx_valid_r) begin
          rx_cnt_nxt = CNT_W'(SETTLE_CYC);
          rx_st_nxt = RX_SEL;
        end
      end
      RX_SEL: begin
        sel_act = 1'b1;
        rx_cnt_nxt = rx_cnt_r - 1'b1;
        if (rx_cnt_r == CNT_W'(1)) begin
          rx_char_nxt = cfg_r.data_inv ? ~din.out_data : din.out_data;
          rx_valid_nxt = 1'b1;
          rx_cnt_nxt = CNT_W'(STROBE_CYC);
          rx_st_nxt = RX_ACK;
        end
      end
      RX_ACK: begin
        sel_act = 1'b1;
        rfo_act = 1'b1;
        rx_cnt_nxt = rx_cnt_r - 1'b1;
        if (rx_cnt_r == CNT_W'(1)) begin
          rx_cnt_nxt = CNT_W'(RELEASE_CYC);
          rx_st_nxt = RX_REL;
        end
      end
      RX_REL: begin
        // trailing edge of ready-for-output clears the device side
        rfo_act = 1'b0;
        rx_cnt_nxt = rx_cnt_r - 1'b1;
        if (rx_cnt_r == CNT_W'(1)) begin
          rx_st_nxt = RX_IDLE;
        end
      end
      default: rx_st_nxt = RX_IDLE;
    endcase
    pins_nxt.in_data = cfg_r.data_inv ? ~tx_char_nxt : tx_char_nxt;
    pins_nxt.in_strobe = strobe_act ~^ cfg_r.strobe_rise;
    pins_nxt.xmit_sel = sel_act ~^ cfg_r.xsel_high;
    pins_nxt.ready_for_output = rfo_act ~^ cfg_r.rfo_pos;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_st_r <= TX_IDLE;
      tx_char_r <= 7'h00;
      tx_cnt_r <= 3'h0;
      rx_st_r <= RX_IDLE;
      rx_cnt_r <= 3'h0;
      rx_char_r <= 7'h00;
      rx_valid_r <= 1'b0;
      pins_r <= {7'h7f, 1'b0, 1'b0, 1'b0};
    end else begin
      tx_st_r <= tx_st_nxt;
      tx_char_r <= tx_char_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      rx_st_r <= rx_st_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_char_r <= rx_char_nxt;
      rx_valid_r <= rx_valid_nxt;
      pins_r <= pins_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign dev_o = pins_r;
endmodule

// ==== test/hp_host_sva.sv ====
// hp_host_sva: port timing checks for the host controller.
// assumes one clock domain; bound into every hp_host instance.
`timescale 1ns/10ps
module hp_host_sva
  import hp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire hp_dev_in_t dev_i,
  input wire hp_dev_out_t dev_o
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rfo_gap;
    !dev_o.ready_for_output [*6];
  endsequence
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
  chk_b_latency: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during response");
  chk_rd_slverr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read not refused");
  chk_strobe_width: assert property ($changed(dev_o.in_strobe)
    |=> $stable(dev_o.in_strobe) [*2]) else $error("input strobe too short");
  chk_data_steady: assert property ($rose(dev_o.in_strobe)
    |-> $stable(dev_o.in_data) [*4]) else $error("input data moved under strobe");
  chk_accept_first: assert property ($rose(dev_o.in_strobe)
    |-> $past(dev_i.rx_accept_flag, 3)) else $error("strobe without accept flag");
  chk_rfo_trail: assert property ($fell(dev_o.ready_for_output) |-> s_rfo_gap)
    else $error("acknowledge trailing gap too short");
endmodule

bind hp_host hp_host_sva u_sva (.core_clk(core_clk), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .dev_i(dev_i), .dev_o(dev_o));

// ==== test/hp_dev_model.sv ====
// hp_dev_model: behavioural terminal port that the host controller drives.
// assumes active-high select, acknowledge and output-ready, rising input strobe.
`timescale 1ns/10ps
module hp_dev_model
  import hp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire hp_dev_out_t dev_o,
  output hp_dev_in_t dev_i,
  input wire logic inv,
  input wire logic in_off_n,
  input wire logic in_off,
  input wire logic kb_stb,
  input wire logic [6:0] kb_char,
  input wire logic [7:0] mf_dly,
  output logic [6:0] got_char,
  output logic [7:0] got_n
);
  logic acc, lock, ordy, tgl, stb_q, rfo_q;
  logic [1:0] cap_q;
  logic [6:0] odata;
  logic [7:0] mf_cnt;
  // released lines toggle each cycle so a stale value never looks valid
  assign dev_i = {acc, (dev_o.xmit_sel ? odata : ~odata ^ {7{tgl}}),
    (dev_o.xmit_sel ? ordy : tgl), ordy & dev_o.ready_for_output, ~ordy};
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {lock, ordy, tgl, stb_q, rfo_q, cap_q} <= '0;
      {odata, mf_cnt, got_char, got_n} <= '0;
      acc <= 1'b1;
    end else begin
      tgl <= ~tgl;
      stb_q <= dev_o.in_strobe;
      rfo_q <= dev_o.ready_for_output;
      cap_q <= {cap_q[0], dev_o.in_strobe & ~stb_q & in_off_n & ~in_off & acc};
      if (cap_q[1]) begin
        got_char <= inv ? ~dev_o.in_data : dev_o.in_data;
        got_n <= got_n + 8'h01;
      end
      if (cap_q[0]) begin
        acc <= 1'b0;
        mf_cnt <= mf_dly;
      end else if (!acc && mf_cnt != 8'h00) begin
        mf_cnt <= mf_cnt - 8'h01;
      end else begin
        acc <= 1'b1;
      end
      if (kb_stb && !lock) begin
        lock <= 1'b1;
        ordy <= 1'b1;
        odata <= inv ? ~kb_char : kb_char;
      end else if (rfo_q && !dev_o.ready_for_output) begin
        lock <= 1'b0;
        ordy <= 1'b0;
      end
    end
  end
endmodule

// ==== test/hp_host_tb_top.sv ====
// hp_host_tb_top: self-checking bench for the host controller against a device model.
// assumes hp_pkg, hp_host, hp_dev_model and the checker are compiled first.
`timescale 1ns/10ps
module hp_host_tb_top;
  import hp_pkg::*;
  logic core_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, inv, in_off_n, in_off, kb_stb;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic [6:0] kb_char, got_char;
  logic [7:0] mf_dly, got_n;
  hp_dev_in_t dev_i;
  hp_dev_out_t dev_o;
  int fails, cmp_count;
  hp_host u_dut (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .dev_i(dev_i), .dev_o(dev_o));
  hp_dev_model u_dev (.core_clk(core_clk), .rst(rst), .dev_o(dev_o), .dev_i(dev_i),
    .inv(inv), .in_off_n(in_off_n), .in_off(in_off), .kb_stb(kb_stb), .kb_char(kb_char),
    .mf_dly(mf_dly), .got_char(got_char), .got_n(got_n));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tmo(input string nm);
    fails++;
    $display("[ERR] %s expected done seen timeout", nm);
    stop_test();
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    rs = bresp;
    bready <= 1'b0;
    if (n >= 100) tmo("write");
    @(posedge core_clk);
  endtask
  task automatic rd_reg(input logic [3:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (n >= 100) tmo("read");
    @(posedge core_clk);
  endtask
  task automatic wait_stat(input int b, input logic v);
    int n;
    n = 0;
    do begin
      rd_reg(ADDR_STATUS);
      n++;
    end while (rd[b] !== v && n < 200);
    if (n >= 200) tmo("status");
  endtask
  task automatic t_regs();
    rd_reg(ADDR_CTRL);
    check("ctrl reset", 32'h1f, rd);
    rd_reg(ADDR_STATUS);
    check("status idle", 32'h4, rd);
    rd_reg(4'h2);
    check("bad read resp", 32'(RESP_SLVERR), 32'(rs));
    check("bad read data", 32'h0, rd);
    wr(4'h2, 32'h0);
    check("bad write resp", 32'(RESP_SLVERR), 32'(rs));
    $display("t_regs done");
  endtask
  task automatic t_send();
    logic [7:0] n0;
    n0 = got_n;
    mf_dly <= 8'd60;
    wr(ADDR_TXDATA, 32'h3f);
    check("in_data pins", 32'h40, 32'(dev_o.in_data));
    // a second char while busy is answered but dropped
    wr(ADDR_TXDATA, 32'h2a);
    check("busy write resp", 32'(RESP_OKAY), 32'(rs));
    check("in_data held", 32'h40, 32'(dev_o.in_data));
    wait_stat(STAT_BUSY, 1'b0);
    check("sent count", 32'(n0 + 8'h01), 32'(got_n));
    check("sent char", 32'h3f, 32'(got_char));
    mf_dly <= 8'd4;
    wr(ADDR_TXDATA, 32'h00);
    wait_stat(STAT_BUSY, 1'b0);
    check("fast char", 32'h0, 32'(got_char));
    $display("t_send done");
  endtask
  task automatic t_rx(input logic [31:0] ctrl, input logic [6:0] c);
    wr(ADDR_CTRL, ctrl);
    inv <= ctrl[0];
    repeat (4) @(posedge core_clk);
    if (ctrl[6:5] == MODE_POLL) check("poll select", 32'h1, 32'(dev_o.xmit_sel));
    if (ctrl[6:5] == MODE_LEVEL) check("level rfo", 32'h1, 32'(dev_o.ready_for_output));
    kb_char <= c;
    kb_stb <= 1'b1;
    @(posedge core_clk);
    kb_stb <= 1'b0;
    kb_char <= ~c;
    @(posedge core_clk);
    kb_stb <= 1'b1;
    @(posedge core_clk);
    kb_stb <= 1'b0;
    wait_stat(STAT_RXVALID, 1'b1);
    rd_reg(ADDR_RXDATA);
    check("rx char", 32'(c), rd);
    repeat (30) @(posedge core_clk);
    rd_reg(ADDR_STATUS);
    check("rx released", 32'h4, rd);
    $display("t_rx done");
  endtask
  task automatic t_off();
    logic [7:0] n0;
    for (int i = 0; i < 2; i++) begin
      in_off_n <= (i != 0);
      in_off <= (i == 1);
      n0 = got_n;
      wr(ADDR_TXDATA, 32'h55);
      repeat (40) @(posedge core_clk);
      check("off count", 32'(n0), 32'(got_n));
      rd_reg(ADDR_STATUS);
      check("off status", 32'h5, rd);
      in_off_n <= 1'b1;
      in_off <= 1'b0;
      // the stranded send only clears by reset
      do_reset();
    end
    $display("t_off done");
  endtask
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, kb_stb, in_off} = '0;
    {awaddr, araddr, wstrb, wdata, kb_char} = '0;
    {inv, in_off_n} = 2'b11;
    mf_dly = 8'h04;
    fails = 0;
    cmp_count = 0;
    do_reset();
    t_regs();
    t_send();
    t_rx(32'h1f, 7'h41);
    t_rx(32'h3f, 7'h15);
    t_rx(32'h5f, 7'h6a);
    t_rx(32'h1e, 7'h7f);
    t_off();
    stop_test();
  end
endmodule
